// ==== core/msm_pkg.sv ====
// Package with register map, field positions and reset values for the mode/map block
package msm_pkg;
  // Register byte addresses
  localparam logic [15:0] ADDR_NVM_PROG   = 16'h103b;
  localparam logic [15:0] ADDR_PRIO_MODE  = 16'h103c;
  localparam logic [15:0] ADDR_RAM_REG    = 16'h103d;
  localparam logic [15:0] ADDR_RSVD       = 16'h103e;
  localparam logic [15:0] ADDR_STARTUP    = 16'h103f;
  // Reset values
  localparam logic [7:0]  NVM_PROG_RST    = 8'h00;
  localparam logic [3:0]  PSEL_RST        = 4'h6;
  localparam logic [7:0]  RAM_REG_RST     = 8'h01;
  localparam logic [3:0]  EE_POS_RST      = 4'hf;
  // Priority register field positions
  localparam int          BOOT_BIT        = 7;
  localparam int          SPECIAL_MODE_FLAG_BIT        = 6;
  localparam int          MDA_BIT         = 5;
  localparam int          IRV_BIT         = 4;
  // Startup configuration field positions
  localparam int          SECURITY_DISABLE_BIT       = 3;
  localparam int          WATCHDOG_DISABLE_BIT       = 2;
  localparam int          INTERNAL_ROM_ON_BIT       = 1;
  localparam int          EEPROM_ON_BIT        = 0;
  // Fixed map windows
  localparam logic [15:0] BOOT_LO         = 16'hbf00;
  localparam logic [15:0] BOOT_HI         = 16'hbfff;
  localparam logic [15:0] EE512_LO        = 16'hb600;
  localparam logic [15:0] EE512_HI        = 16'hb7ff;
  localparam logic [15:0] EE2K_OFS        = 16'h0800;
  localparam logic [15:0] VEC_NORMAL      = 16'hfffa;
  localparam logic [15:0] VEC_SPECIAL     = 16'hbffa;
  // Protected write window after reset, in cycles
  localparam int          PROT_CYCLES     = 64;
  localparam logic [6:0]  PROT_COUNT      = 7'(PROT_CYCLES);
  // Resource selected for a cpu access
  typedef enum logic [2:0] {
    MSM_SEL_NONE, MSM_SEL_REG, MSM_SEL_RAM, MSM_SEL_BOOT, MSM_SEL_EEPROM, MSM_SEL_ROM
  } msm_sel_t;
  // Operating modes
  typedef enum logic [1:0] {
    MSM_SINGLE, MSM_EXPANDED, MSM_BOOTSTRAP, MSM_TEST
  } msm_mode_t;
endpackage

// ==== core/msm_top.sv ====
// Mode latch, memory map resolver and system registers
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Registers beat RAM, RAM beats ROM
// - Boot ROM mapped while boot and special bits are set
// - ROM on always, expanded needs ROM-on bit
// - Small EEPROM fixed at B600-B7FF
// - Large EEPROM placed by position nibble
// - Mode pins sampled only during reset
// - Pin pairs map to boot, special, A bits
// - Pin A drives fetch marker low, open drain
// - Vector base FFFA normal, BFFA special
// - Priority bits reset 0110, upper by mode
// - Boot enable writable only in special modes
// - Visibility resets 1 only in test mode
// - Protected bits once in 64 cycles normally
// - Config keeps programmed bits through reset
// - Mode A once in normal modes; special never re-set
// - Visibility: bus drive or E held low
// - Config copied to latches each reset
module msm_top #(
  parameter bit         EE_2K     = 1'b0,     // Large remappable EEPROM variant
  parameter logic [7:0] NV_CONFIG_INIT = 8'hff // Initial nonvolatile config byte
) (
  input  wire logic           clock,          // System clock
  input  wire logic           rstn,           // Synchronous reset, low active
  input  wire logic           mode_pin_a_in,  // Mode pin A level
  output logic                mode_pin_a_out, // Mode pin A drive value
  output logic                mode_pin_a_oe,  // Mode pin A drive enable
  input  wire logic           mode_pin_b,     // Mode pin B level
  input  wire logic           fetch_first,    // First E cycle of an instruction
  input  wire logic [15:0]    cpu_addr,       // Cpu access address
  input  wire logic           cpu_read,       // Cpu read in progress
  output msm_pkg::msm_sel_t   cpu_sel,        // Resource that answers the access
  output logic [15:0]         vector_base,    // Reset vector base address
  output logic                e_pin_low,      // Hold E pin low
  output logic                ext_read_vis,   // Drive internal reads on external bus
  output logic                security_off,   // Security disable latch
  output logic                watchdog_off,   // Watchdog disable latch
  input  wire logic [7:0]     nv_write_data,  // Programmed value for config byte
  input  wire logic           nv_write,       // Program strobe for config byte
  input  wire logic [15:0]    reg_addr,       // Register address
  input  wire logic [7:0]     reg_wdata,      // Register write data
  input  wire logic           reg_write,      // Register write strobe
  input  wire logic           reg_read,       // Register read strobe
  output logic [7:0]          reg_rdata       // Register read data, next cycle
);
  import msm_pkg::*;

  // Synchronisers for the mode pins
  logic [1:0] pa_sync_reg;                    // Pin A two-stage sync
  logic [1:0] pb_sync_reg;                    // Pin B two-stage sync
  // Register state
  logic       boot_reg, special_mode_flag_reg, mda_reg, irv_reg; // Priority register upper bits
  logic [3:0] psel_reg;                       // Priority select nibble
  logic [7:0] nvm_reg;                        // Programming control
  logic [7:0] place_reg;                      // RAM and register placement
  logic [7:0] nv_cell_reg = NV_CONFIG_INIT;   // Nonvolatile config byte, power-up value
  logic [7:0] cfg_reg;                        // Working config latches
  logic [6:0] prot_cnt_reg;                   // Cycles since reset release
  logic       place_done_reg;                 // Placement written once
  logic       mda_done_reg;                   // Mode A written once
  logic       irv_done_reg;                   // Visibility written once
  logic [7:0] rdata_reg;                      // Read data register
  logic       mode_b_lat, mode_a_lat;         // Levels latched during reset
  msm_mode_t  mode;                           // Decoded operating mode

  // Two flip-flop synchronisers
  always_ff @(posedge clock) begin
    pa_sync_reg <= {pa_sync_reg[0], mode_pin_a_in};
    pb_sync_reg <= {pb_sync_reg[0], mode_pin_b};
  end

  // Pin levels followed while reset is low, held after release
  // sample only during reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_a_lat <= pa_sync_reg[1];
      mode_b_lat <= pb_sync_reg[1];
    end
  end

  // Mode decode from latched levels
  always_comb begin
    case ({mode_b_lat, mode_a_lat})
      2'b10:   mode = MSM_SINGLE;
      2'b11:   mode = MSM_EXPANDED;
      2'b00:   mode = MSM_BOOTSTRAP;
      2'b01:   mode = MSM_TEST;
      default: mode = MSM_SINGLE;
    endcase
  end

  // Write qualifiers
  logic wr_prio, wr_place, wr_nvm, window_open;
  assign wr_prio     = reg_write && (reg_addr == ADDR_PRIO_MODE);
  assign wr_place    = reg_write && (reg_addr == ADDR_RAM_REG);
  assign wr_nvm      = reg_write && (reg_addr == ADDR_NVM_PROG);
  assign window_open = (prot_cnt_reg < PROT_COUNT);

  // Protected window counter
  always_ff @(posedge clock) begin
    if (!rstn) begin
      prot_cnt_reg <= '0;
    end else if (window_open) begin
      prot_cnt_reg <= prot_cnt_reg + 7'h01;
    end
  end

  // Priority register upper bits
  // reset values from pins
  // visibility and boot enable by mode
  always_ff @(posedge clock) begin
    if (!rstn) begin
      boot_reg     <= !pb_sync_reg[1] && !pa_sync_reg[1];
      special_mode_flag_reg     <= !pb_sync_reg[1];
      mda_reg      <= pa_sync_reg[1];
      irv_reg      <= !pb_sync_reg[1] && pa_sync_reg[1];
      mda_done_reg <= 1'b0;
      irv_done_reg <= 1'b0;
    end else if (wr_prio) begin
      // boot enable only in special modes
      if (special_mode_flag_reg) begin
        boot_reg <= reg_wdata[BOOT_BIT];
      end
      if (!reg_wdata[SPECIAL_MODE_FLAG_BIT]) begin
        special_mode_flag_reg <= 1'b0;
      end
      // mode A once in normal modes
      if (special_mode_flag_reg || !mda_done_reg) begin
        mda_reg      <= reg_wdata[MDA_BIT];
        mda_done_reg <= 1'b1;
      end
      // Visibility written once in any mode
      if (!irv_done_reg) begin
        irv_reg      <= reg_wdata[IRV_BIT];
        irv_done_reg <= 1'b1;
      end
    end
  end

  // Priority select nibble
  // resets to 0110
  always_ff @(posedge clock) begin
    if (!rstn) begin
      psel_reg <= PSEL_RST;
    end else if (wr_prio) begin
      psel_reg <= reg_wdata[3:0];
    end
  end

  // Placement register
  // once within window, anytime special
  always_ff @(posedge clock) begin
    if (!rstn) begin
      place_reg      <= RAM_REG_RST;
      place_done_reg <= 1'b0;
    end else if (wr_place && (special_mode_flag_reg || (window_open && !place_done_reg))) begin
      place_reg      <= reg_wdata;
      place_done_reg <= 1'b1;
    end
  end

  // Programming control register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      nvm_reg <= NVM_PROG_RST;
    end else if (wr_nvm) begin
      nvm_reg <= reg_wdata;
    end
  end

  // Nonvolatile cell, survives reset
  // Only programming changes it; reset must never touch it
  always_ff @(posedge clock) begin
    if (nv_write) begin
      nv_cell_reg <= nv_write_data;
    end
  end

  // Working latches loaded during reset
  // copy config during reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cfg_reg <= '0;
      cfg_reg[SECURITY_DISABLE_BIT] <= nv_cell_reg[SECURITY_DISABLE_BIT];
      cfg_reg[WATCHDOG_DISABLE_BIT] <= nv_cell_reg[WATCHDOG_DISABLE_BIT];
      cfg_reg[EEPROM_ON_BIT]  <= nv_cell_reg[EEPROM_ON_BIT];
      cfg_reg[INTERNAL_ROM_ON_BIT] <= nv_cell_reg[INTERNAL_ROM_ON_BIT];
      if (EE_2K) begin
        cfg_reg[7:4] <= nv_cell_reg[7:4];
      end
    end
  end

  // Read data one cycle after strobe
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_NVM_PROG:  rdata_reg <= nvm_reg;
        ADDR_PRIO_MODE: rdata_reg <= {boot_reg, special_mode_flag_reg, mda_reg, irv_reg, psel_reg};
        ADDR_RAM_REG:   rdata_reg <= place_reg;
        ADDR_STARTUP:   rdata_reg <= EE_2K ? {cfg_reg[7:2], 1'b1, cfg_reg[0]}
                                           : {4'h0, cfg_reg[3:2], 1'b1, cfg_reg[0]};
        default:        rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end
  assign reg_rdata = rdata_reg;

  // Address map resolution
  logic hit_reg, hit_ram, hit_boot, hit_ee, hit_rom, rom_en;
  assign hit_reg  = (cpu_addr[15:12] == place_reg[3:0]) && (cpu_addr[11:6] == 6'h00);
  assign hit_ram  = (cpu_addr[15:12] == place_reg[7:4]) && (cpu_addr[11:9] == 3'h0);
  assign hit_boot = boot_reg && special_mode_flag_reg && (cpu_addr >= BOOT_LO) && (cpu_addr <= BOOT_HI);
  assign hit_ee   = cfg_reg[EEPROM_ON_BIT] && (EE_2K
                    ? ((cpu_addr[15:12] == cfg_reg[7:4]) && (cpu_addr[11:0] >= EE2K_OFS[11:0]))
                    : ((cpu_addr >= EE512_LO) && (cpu_addr <= EE512_HI)));
  // ROM enable by mode
  // Special test is an expanded mode, so it obeys the ROM-on bit too
  assign rom_en   = (mode == MSM_EXPANDED || mode == MSM_TEST) ? cfg_reg[INTERNAL_ROM_ON_BIT] : 1'b1;
  assign hit_rom  = rom_en && cpu_addr[15];

  always_comb begin
    if (hit_reg)       cpu_sel = MSM_SEL_REG;
    else if (hit_ram)  cpu_sel = MSM_SEL_RAM;
    else if (hit_boot) cpu_sel = MSM_SEL_BOOT;
    else if (hit_ee)   cpu_sel = MSM_SEL_EEPROM;
    else if (hit_rom)  cpu_sel = MSM_SEL_ROM;
    else               cpu_sel = MSM_SEL_NONE;
  end

  assign vector_base = mode_b_lat ? VEC_NORMAL : VEC_SPECIAL;

  assign ext_read_vis = irv_reg && mda_reg && cpu_read;
  assign e_pin_low    = irv_reg && !mda_reg;
  assign security_off = cfg_reg[SECURITY_DISABLE_BIT];
  assign watchdog_off = cfg_reg[WATCHDOG_DISABLE_BIT];

  // open drain fetch marker out of reset
  assign mode_pin_a_out = 1'b0;
  assign mode_pin_a_oe  = rstn && fetch_first;

  // a_ Protected placement write refused after window
  a_place_lock: assert property (@(posedge clock) disable iff (!rstn)
    (wr_place && !special_mode_flag_reg && !window_open) |=> $stable(place_reg))
    else $error("placement changed after window");
  a_special_mode_flag_sticky: assert property (@(posedge clock) disable iff (!rstn)
    (!special_mode_flag_reg) |=> !special_mode_flag_reg)
    else $error("special bit set again");
  a_boot_map: assert property (@(posedge clock) disable iff (!rstn)
    (cpu_sel == MSM_SEL_BOOT) |-> (cpu_addr[15:8] == 8'hbf) && boot_reg)
    else $error("boot rom outside window");
  a_reg_first: assert property (@(posedge clock) disable iff (!rstn)
    hit_reg |-> cpu_sel == MSM_SEL_REG)
    else $error("register block lost priority");
  a_psel_reset: assert property (@(posedge clock)
    !rstn |=> psel_reg == 4'h6)
    else $error("priority select reset wrong");
  a_mode_hold: assert property (@(posedge clock) disable iff (!rstn)
    $stable(mode_a_lat) && $stable(mode_b_lat))
    else $error("mode changed after reset");
  a_marker_drive: assert property (@(posedge clock)
    mode_pin_a_oe |-> rstn && fetch_first && !mode_pin_a_out)
    else $error("marker driven wrongly");
  a_vector_sel: assert property (@(posedge clock) disable iff (!rstn)
    vector_base == ((mode == MSM_SINGLE || mode == MSM_EXPANDED) ? VEC_NORMAL : VEC_SPECIAL))
    else $error("vector base wrong");
  a_read_data: assert property (@(posedge clock) disable iff (!rstn)
    (reg_read && reg_addr == ADDR_PRIO_MODE) |=> reg_rdata[3:0] == $past(psel_reg))
    else $error("priority read wrong");
  // Map and latch checks
  a_rom_enable: assert property (@(posedge clock) disable iff (!rstn)
    (mode == MSM_SINGLE || mode == MSM_BOOTSTRAP) |-> rom_en)
    else $error("rom not enabled in single chip or bootstrap");
  a_ee_fixed: assert property (@(posedge clock) disable iff (!rstn)
    (!EE_2K && cfg_reg[EEPROM_ON_BIT] && cpu_addr[15:9] == EE512_LO[15:9] && !hit_reg && !hit_ram)
    |-> cpu_sel == MSM_SEL_EEPROM)
    else $error("small eeprom not at fixed window");
  a_cfg_hold: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) |-> $stable(cfg_reg))
    else $error("config latches changed outside reset");
  a_reset_bits: assert property (@(posedge clock)
    $rose(rstn) |-> (irv_reg == (mode == MSM_TEST)) && (boot_reg == (mode == MSM_BOOTSTRAP)))
    else $error("visibility or boot enable reset wrong");
endmodule
`default_nettype wire

// ==== verif/msm_core_model.sv ====
// Core-side model: mode pin levels, open-drain marker wire and fetch timing
`timescale 1ns/1ns
`default_nettype none
module msm_core_model (
  input  wire logic clock,          // System clock
  input  wire logic rstn,           // Reset, low active
  input  wire logic pin_a_level,    // Board level on pin A
  input  wire logic pin_b_level,    // Board level on pin B
  input  wire logic mode_pin_a_out, // Device drive value
  input  wire logic mode_pin_a_oe,  // Device drive enable
  output logic      mode_pin_a_in,  // Resolved pin A level
  output logic      mode_pin_b,     // Pin B level
  output logic      fetch_first     // First cycle of an instruction
);
  logic [1:0] phase_reg;            // Instruction phase counter
  // Known values before the first edge
  initial begin
    phase_reg = 2'h0;
    fetch_first = 1'b0;
  end
  // open drain wire
  // Device pull-down wins, otherwise the board level shows
  assign mode_pin_a_in = (mode_pin_a_oe && !mode_pin_a_out) ? 1'b0 : pin_a_level;
  assign mode_pin_b = pin_b_level;
  // Three cycle instructions, marker in the first, also during reset
  always @(posedge clock) begin
    phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
    fetch_first <= (phase_reg == 2'h2);
  end
endmodule
`default_nettype wire

// ==== verif/mode_select_memory_map_tb_top.sv ====
// Self-checking bench for the mode latch and memory map block
`timescale 1ns/1ns
`default_nettype none
module mode_select_memory_map_tb_top;
  import msm_pkg::*;
  logic        clock = 1'b0;     // System clock
  logic        rstn = 1'b0;      // Reset, low active
  logic        pa = 1'b1;        // Board level pin A
  logic        pb = 1'b1;        // Board level pin B
  logic        a_in, a_out, a_oe, b_in, ff; // Pin and marker wires
  logic [15:0] cpu_addr = 16'h0000; // Core access address
  logic        cpu_read = 1'b0;  // Core read
  msm_sel_t    cpu_sel;          // Selected resource
  logic [15:0] vector_base;      // Vector base
  logic        e_low, rvis, sec_off, wd_off; // Misc outputs
  logic [7:0]  nv_data = 8'h00;  // Config program data
  logic        nv_write = 1'b0;  // Config program strobe
  logic [15:0] reg_addr = 16'h0000; // Register address
  logic [7:0]  reg_wdata = 8'h00;   // Register write data
  logic        reg_write = 1'b0; // Write strobe
  logic        reg_read = 1'b0;  // Read strobe
  logic [7:0]  reg_rdata;        // Read data
  int          bad_count = 0;    // Mismatches
  int          n_checks = 0;     // Comparisons
  // 4 ns clock
  always #2 clock = ~clock;
  msm_core_model core (.clock(clock), .rstn(rstn), .pin_a_level(pa), .pin_b_level(pb),
    .mode_pin_a_out(a_out), .mode_pin_a_oe(a_oe), .mode_pin_a_in(a_in),
    .mode_pin_b(b_in), .fetch_first(ff));
  msm_top #(.EE_2K(1'b0), .NV_CONFIG_INIT(8'hff)) dut (.clock(clock), .rstn(rstn),
    .mode_pin_a_in(a_in), .mode_pin_a_out(a_out), .mode_pin_a_oe(a_oe), .mode_pin_b(b_in),
    .fetch_first(ff), .cpu_addr(cpu_addr), .cpu_read(cpu_read), .cpu_sel(cpu_sel),
    .vector_base(vector_base), .e_pin_low(e_low), .ext_read_vis(rvis),
    .security_off(sec_off), .watchdog_off(wd_off), .nv_write_data(nv_data),
    .nv_write(nv_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Register read, data checked in the following cycle
  task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(what, 16'(reg_rdata), 16'(exp));
  endtask
  // Present an address and check the chosen resource
  task automatic sel(input logic [15:0] a, input msm_sel_t exp);
    @(posedge clock);
    cpu_addr <= a;
    cpu_read <= 1'b1;
    #1 chk("cpu_sel", 16'(cpu_sel), 16'(exp));
  endtask
  // Reset with given pin levels, marker must stay off meanwhile
  task automatic do_reset(input logic b, input logic a);
    @(posedge clock);
    rstn <= 1'b0;
    pb <= b;
    pa <= a;
    repeat (4) begin
      @(posedge clock);
      #1 chk("marker_oe_reset", 16'(a_oe), 16'h0000);
    end
    @(posedge clock);
    rstn <= 1'b1;
  endtask
  // Expected priority register after reset
  function automatic logic [7:0] prio_exp(input logic b, input logic a);
    return {!b && !a, !b, a, !b && a, PSEL_RST};
  endfunction
  // Linear feedback shift register
  function automatic logic [7:0] lfsr(input logic [7:0] l);
    return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
  endfunction
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    logic b, a;
    logic [7:0] l;
    l = 8'h3b;
    // Every pin pair, pins moved right after release
    for (int m = 0; m < 4; m++) begin
      b = m[1];
      a = m[0];
      do_reset(b, a);
      pa <= !a;
      pb <= !b;
      rchk("prio_reset", ADDR_PRIO_MODE, prio_exp(b, a));
      sel(BOOT_LO, (!b && !a) ? MSM_SEL_BOOT : MSM_SEL_ROM);
      sel(BOOT_HI, (!b && !a) ? MSM_SEL_BOOT : MSM_SEL_ROM);
      sel(EE512_LO, MSM_SEL_EEPROM);
      sel(EE512_HI, MSM_SEL_EEPROM);
      sel(16'hfffe, MSM_SEL_ROM);
      sel(16'h1000, MSM_SEL_REG);
      sel(16'h01ff, MSM_SEL_RAM);
      sel(16'h4000, MSM_SEL_NONE);
      chk("vector", vector_base, b ? VEC_NORMAL : VEC_SPECIAL);
      chk("read_vis_reset", 16'(rvis), 16'(!b && a));
      chk("marker_oe", 16'(a_oe), 16'(ff));
      chk("marker_out", 16'(a_out), 16'h0000);
      wr(ADDR_PRIO_MODE, prio_exp(b, a) | 8'h10);
      rchk("prio_stable", ADDR_PRIO_MODE, prio_exp(b, a) | 8'h10);
      chk("e_low", 16'(e_low), 16'(!a));
      chk("read_vis", 16'(rvis), 16'(a));
    end
    // Special test: overlapping pages, written late
    do_reset(1'b0, 1'b1);
    wr(ADDR_RAM_REG, 8'h00);
    sel(16'h0000, MSM_SEL_REG);
    sel(16'h0040, MSM_SEL_RAM);
    repeat (70) @(posedge clock);
    wr(ADDR_RAM_REG, 8'h88);
    sel(16'h8000, MSM_SEL_REG);
    sel(16'h8100, MSM_SEL_RAM);
    sel(16'h8300, MSM_SEL_ROM);
    // Single chip: placement once, early only
    do_reset(1'b1, 1'b0);
    wr(ADDR_RAM_REG, 8'h21);
    wr(ADDR_RAM_REG, 8'h31);
    rchk("placement_once", ADDR_RAM_REG, 8'h21);
    sel(16'h2000, MSM_SEL_RAM);
    do_reset(1'b1, 1'b0);
    repeat (70) @(posedge clock);
    wr(ADDR_RAM_REG, 8'h33);
    rchk("placement_late", ADDR_RAM_REG, RAM_REG_RST);
    wr(ADDR_PRIO_MODE, 8'hff);
    rchk("prio_normal", ADDR_PRIO_MODE, 8'h3f);
    wr(ADDR_PRIO_MODE, 8'h00);
    rchk("prio_once", ADDR_PRIO_MODE, 8'h30);
    // Bootstrap: boot enable cleared, special bit lost for good
    do_reset(1'b0, 1'b0);
    wr(ADDR_PRIO_MODE, 8'h46);
    rchk("boot_off", ADDR_PRIO_MODE, 8'h46);
    sel(BOOT_LO, MSM_SEL_ROM);
    wr(ADDR_PRIO_MODE, 8'h06);
    wr(ADDR_PRIO_MODE, 8'hc6);
    rchk("special_lost", ADDR_PRIO_MODE, 8'h06);
    // Random priority select values
    for (int i = 0; i < 8; i++) begin
      l = lfsr(l);
      wr(ADDR_PRIO_MODE, {4'h0, l[3:0]});
      rchk("psel", ADDR_PRIO_MODE, {4'h0, l[3:0]});
    end
    // Config programming takes effect only after reset
    rchk("config", ADDR_STARTUP, 8'h0f);
    @(posedge clock);
    nv_write <= 1'b1;
    @(posedge clock);
    nv_write <= 1'b0;
    rchk("config_latched", ADDR_STARTUP, 8'h0f);
    chk("sec_before", 16'(sec_off), 16'h0001);
    do_reset(1'b1, 1'b1);
    rchk("config_reset", ADDR_STARTUP, 8'h02);
    chk("sec_after", 16'(sec_off), 16'h0000);
    chk("wd_after", 16'(wd_off), 16'h0000);
    sel(16'hfffe, MSM_SEL_NONE);
    // Plain and reserved registers
    rchk("nvm_prog", ADDR_NVM_PROG, NVM_PROG_RST);
    wr(ADDR_NVM_PROG, 8'h55);
    rchk("nvm_prog_rw", ADDR_NVM_PROG, 8'h55);
    wr(ADDR_RSVD, 8'haa);
    rchk("reserved", ADDR_RSVD, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
